// >>> common/btpd_pkg.sv
// Shared constants, register map and types of the position decoder
package btpd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int REF_HOLD_NS   = 100000;
  localparam int REF_HOLD_CYC  = REF_HOLD_NS / CLK_PERIOD_NS;
  localparam int HOLD_W        = $clog2(REF_HOLD_CYC);
  localparam logic [HOLD_W-1:0] REF_HOLD_LAST = HOLD_W'(REF_HOLD_CYC - 1);

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W    = 16;
  localparam int ADDR_W   = 5;
  localparam int CTRL_W   = 4;
  localparam int PPF_W    = 16;
  localparam int FRAME_W  = 32;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PPF    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_START  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CMD    = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_FRAME  = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_SUB    = 5'h18;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_TACH_BIT   = 0;
  localparam int CTRL_BLEAD_BIT  = 1;
  localparam int CTRL_TACHHI_BIT = 2;
  localparam int CTRL_POSREF_BIT = 3;
  localparam int CMD_LOAD_BIT    = 0;
  localparam int ST_DIR_BIT      = 0;
  localparam int ST_LOADED_BIT   = 1;
  localparam int ST_SEQERR_BIT   = 2;
  localparam int ST_LIVE_BIT     = 3;

  localparam logic [CTRL_W-1:0]  CTRL_RESET  = 4'h0;
  localparam logic [PPF_W-1:0]   PPF_RESET   = 16'h0004;
  localparam logic [PPF_W-1:0]   PPF_ONE     = 16'h0001;
  localparam logic [FRAME_W-1:0] START_RESET = 32'h0000_0000;
  localparam logic [FRAME_W-1:0] FRAME_ONE   = 32'h0000_0001;
  localparam logic [1:0]         RESP_OKAY   = 2'h0;
  localparam logic [1:0]         RESP_SLVERR = 2'h2;

  typedef enum logic {BTPD_BIPHASE, BTPD_TACH} btpd_mode_e;

endpackage

// >>> src/btpd_sync2.sv
// Two-flop level synchroniser, any width
`timescale 1ns/1ns
module btpd_sync2 #(
  parameter int WIDTH = 1
)(
  input  logic             clk,
  input  logic             rst,
  input  logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// >>> src/btpd_link_decode.sv
// Link-side quadrature and tach decoder with gray-coded pulse count
`timescale 1ns/1ns
module btpd_link_decode
  import btpd_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
)(
  input  logic                 linkClk,
  input  logic                 linkRst,
  input  logic                 encA,
  input  logic                 encB,
  input  logic                 cfgTach,
  input  logic                 cfgBLeads,
  input  logic                 cfgTachHigh,
  output logic [CNT_WIDTH-1:0] grayCnt,
  output logic                 dirFwd,
  output logic                 errToggle
);

  logic [1:0]           abNow;
  logic [2:0]           cfgS;
  logic [1:0]           abPrev_r;
  logic [CNT_WIDTH-1:0] cnt_r;
  logic [CNT_WIDTH-1:0] cnt_nxt;
  logic [1:0]           dq;
  logic                 step;
  logic                 fwd;
  logic                 err;
  logic                 dir_nxt;
  btpd_mode_e           mode;

  btpd_sync2 #(.WIDTH(2)) u_pinSync (
    .clk (linkClk),
    .rst (linkRst),
    .d   ({encA, encB}),
    .q   (abNow)
  );

  btpd_sync2 #(.WIDTH(3)) u_cfgSync (
    .clk (linkClk),
    .rst (linkRst),
    .d   ({cfgTachHigh, cfgBLeads, cfgTach}),
    .q   (cfgS)
  );

  function automatic logic [1:0] phase(input logic [1:0] ab);
    case (ab)
      2'h0:    phase = 2'h0;
      2'h2:    phase = 2'h1;
      2'h3:    phase = 2'h2;
      default: phase = 2'h3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Step decode
  // ----------------------------------------------------------------
  always_comb
  begin
    mode    = btpd_mode_e'(cfgS[0]);
    dq      = phase(abNow) - phase(abPrev_r);
    step    = 1'b0;
    fwd     = dirFwd;
    err     = 1'b0;
    dir_nxt = dirFwd;
    unique case (mode)
      BTPD_BIPHASE:
      begin
        // Phase step of one means A leads B
        if (dq == 2'h1 || dq == 2'h3)
        begin
          step    = 1'b1;
          fwd     = (dq == 2'h1) ^ cfgS[1];
          dir_nxt = fwd;
        end
        // Skipped state: neither counted nor direction changed
        err = (dq == 2'h2);
      end
      BTPD_TACH:
      begin
        // Only rising edges of A count; B is a static level
        step    = abNow[1] && !abPrev_r[1];
        fwd     = cfgS[2] ? abNow[0] : !abNow[0];
        dir_nxt = fwd;
      end
    endcase
    cnt_nxt = cnt_r;
    if (step)
      cnt_nxt = cnt_r + {{(CNT_WIDTH-1){!fwd}}, 1'b1};
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // One count step per link edge keeps the gray code one bit apart
  always_ff @(posedge linkClk or posedge linkRst)
  begin
    if (linkRst)
    begin
      abPrev_r  <= 2'h0;
      cnt_r     <= '0;
      grayCnt   <= '0;
      dirFwd    <= 1'b1;
      errToggle <= 1'b0;
    end
    else
    begin
      abPrev_r <= abNow;
      cnt_r    <= cnt_nxt;
      grayCnt  <= cnt_nxt ^ (cnt_nxt >> 1);
      dirFwd   <= dir_nxt;
      if (err)
        errToggle <= !errToggle;
    end
  end

endmodule

// >>> src/btpd_top.sv
// Bi-phase / tach position decoder top with AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module btpd_top
  import btpd_pkg::*;
#(
  parameter int                CNT_WIDTH   = CNT_W,
  parameter logic [PPF_W-1:0]  PPF_DEFAULT = PPF_RESET
)(
  input  logic              clk,
  input  logic              rst,
  input  logic              linkClk,
  input  logic              encA,
  input  logic              encB,
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic [2:0]        s_axi_awprot,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic [2:0]        s_axi_arprot,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  output logic              refClkOut,
  output logic              dirFwdOut
);

  logic [1:0]           linkRstPipe_r;
  logic                 linkRst;
  logic                 awHave_r;
  logic                 wHave_r;
  logic [ADDR_W-1:0]    awAddr_r;
  logic [31:0]          wData_r;
  logic [3:0]           wStrb_r;
  logic                 wrFire;
  logic [CTRL_W-1:0]    ctrl_r;
  logic [PPF_W-1:0]     ppf_r;
  logic [FRAME_W-1:0]   start_r;
  logic [31:0]          wrVal;
  logic                 loadPulse;
  logic                 errClr;
  logic [CNT_WIDTH-1:0] grayLink;
  logic [CNT_WIDTH-1:0] graySync;
  logic [CNT_WIDTH-1:0] cntNow;
  logic [CNT_WIDTH-1:0] consumed_r;
  logic [CNT_WIDTH-1:0] diffCnt;
  logic                 dirLink;
  logic                 errTogLink;
  logic [1:0]           statSync;
  logic                 errTogD_r;
  logic                 seqErr_r;
  logic                 loaded_r;
  logic                 stepTick_r;
  logic [FRAME_W-1:0]   frame_r;
  logic [PPF_W-1:0]     sub_r;
  logic [PPF_W-1:0]     ppfM1;
  logic [HOLD_W-1:0]    holdCnt_r;
  logic                 refLive_r;
  logic [31:0]          rdMux;
  logic                 rdHit;

  // ----------------------------------------------------------------
  // Link-domain reset: asserted at once, released on linkClk
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
      linkRstPipe_r <= 2'h3;
    else
      linkRstPipe_r <= {linkRstPipe_r[0], 1'b0};
  end
  assign linkRst = linkRstPipe_r[1];

  btpd_link_decode #(.CNT_WIDTH(CNT_WIDTH)) u_decode (
    .linkClk     (linkClk),
    .linkRst     (linkRst),
    .encA        (encA),
    .encB        (encB),
    .cfgTach     (ctrl_r[CTRL_TACH_BIT]),
    .cfgBLeads   (ctrl_r[CTRL_BLEAD_BIT]),
    .cfgTachHigh (ctrl_r[CTRL_TACHHI_BIT]),
    .grayCnt     (grayLink),
    .dirFwd      (dirLink),
    .errToggle   (errTogLink)
  );

  // Gray pointer changes one bit at a time, so per-bit sync is safe
  btpd_sync2 #(.WIDTH(CNT_WIDTH)) u_cntSync (
    .clk (clk),
    .rst (rst),
    .d   (grayLink),
    .q   (graySync)
  );

  btpd_sync2 #(.WIDTH(2)) u_statSync (
    .clk (clk),
    .rst (rst),
    .d   ({errTogLink, !dirLink}), // Cleared stages mean forward
    .q   (statSync)
  );

  function automatic logic [CNT_WIDTH-1:0] g2b(
    input logic [CNT_WIDTH-1:0] g
  );
    logic [CNT_WIDTH-1:0] b;
    b = '0;
    b[CNT_WIDTH-1] = g[CNT_WIDTH-1];
    for (int i = CNT_WIDTH - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    g2b = b;
  endfunction

  function automatic logic [31:0] strobe(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  st
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    strobe = r;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // A write waits while arready stands, so the read mux selects araddr in the read handshake cycle
  assign wrFire = awHave_r && wHave_r && !s_axi_bvalid
                  && !s_axi_arready;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      awHave_r      <= 1'b0;
      awAddr_r      <= '0;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      if (s_axi_awready && s_axi_awvalid)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
      else if (wrFire)
        awHave_r <= 1'b0;
      else if (!awHave_r && !s_axi_awready && s_axi_awvalid)
        s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_wready <= 1'b0;
      wHave_r      <= 1'b0;
      wData_r      <= '0;
      wStrb_r      <= '0;
    end
    else
    begin
      s_axi_wready <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
      begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      else if (wrFire)
        wHave_r <= 1'b0;
      else if (!wHave_r && !s_axi_wready && s_axi_wvalid)
        s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wrFire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_r <= OFS_SUB) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  assign wrVal = strobe(rdMux, wData_r, wStrb_r);
  assign loadPulse = wrFire && awAddr_r == OFS_CMD && wStrb_r[0]
                     && wData_r[CMD_LOAD_BIT];
  assign errClr = wrFire && awAddr_r == OFS_STATUS && wStrb_r[0]
                  && wData_r[ST_SEQERR_BIT];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r  <= CTRL_RESET;
      ppf_r   <= PPF_DEFAULT;
      start_r <= START_RESET;
    end
    else if (wrFire)
    begin
      if (awAddr_r == OFS_CTRL)
        ctrl_r <= wrVal[CTRL_W-1:0];
      // A zero ratio would wrap ppfM1 and make a frame 65536 steps long
      if (awAddr_r == OFS_PPF)
        ppf_r <= (wrVal[PPF_W-1:0] == '0) ? PPF_ONE : wrVal[PPF_W-1:0];
      if (awAddr_r == OFS_START)
        start_r <= wrVal;
    end
  end

  // ----------------------------------------------------------------
  // Position accumulator
  // ----------------------------------------------------------------
  // Steps drain one per clk; bursts queue up to half the count range
  assign cntNow  = g2b(graySync);
  assign diffCnt = cntNow - consumed_r;
  assign ppfM1   = ppf_r - PPF_ONE;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      consumed_r <= '0;
      stepTick_r <= 1'b0;
      loaded_r   <= 1'b0;
      frame_r    <= START_RESET;
      sub_r      <= '0;
    end
    else if (loadPulse)
    begin
      // Earlier pulses are discarded so counting starts here
      consumed_r <= cntNow;
      frame_r    <= start_r;
      sub_r      <= '0;
      loaded_r   <= 1'b1;
      stepTick_r <= 1'b0;
    end
    else if (diffCnt != '0)
    begin
      consumed_r <= consumed_r
                    + {{(CNT_WIDTH-1){diffCnt[CNT_WIDTH-1]}}, 1'b1};
      stepTick_r <= 1'b1;
      if (ctrl_r[CTRL_POSREF_BIT] && loaded_r)
      begin
        if (!diffCnt[CNT_WIDTH-1])
        begin
          if (sub_r >= ppfM1)
          begin
            sub_r   <= '0;
            frame_r <= frame_r + FRAME_ONE;
          end
          else
            sub_r <= sub_r + PPF_ONE;
        end
        else if (sub_r == '0)
        begin
          sub_r   <= ppfM1;
          frame_r <= frame_r - FRAME_ONE;
        end
        else if (sub_r > ppfM1)
          sub_r <= ppfM1;
        else
          sub_r <= sub_r - PPF_ONE;
      end
    end
    else
      stepTick_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Clock reference: follows pulses, free-runs when transport stops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refClkOut <= 1'b0;
      holdCnt_r <= '0;
      refLive_r <= 1'b0;
    end
    else if (stepTick_r)
    begin
      refClkOut <= !refClkOut;
      holdCnt_r <= '0;
      refLive_r <= 1'b1;
    end
    else if (holdCnt_r == REF_HOLD_LAST)
    begin
      refClkOut <= !refClkOut;
      holdCnt_r <= '0;
      refLive_r <= 1'b0;
    end
    else
      holdCnt_r <= holdCnt_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dirFwdOut <= 1'b1;
      errTogD_r <= 1'b0;
      seqErr_r  <= 1'b0;
    end
    else
    begin
      dirFwdOut <= !statSync[0];
      errTogD_r <= statSync[1];
      // A new error in the clearing cycle keeps the flag set
      if (statSync[1] != errTogD_r)
        seqErr_r <= 1'b1;
      else if (errClr)
        seqErr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb
  begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case (wrFire ? awAddr_r : {s_axi_araddr[ADDR_W-1:2], 2'h0})
      OFS_CTRL:   rdMux = 32'(ctrl_r);
      OFS_PPF:    rdMux = 32'(ppf_r);
      OFS_START:  rdMux = start_r;
      OFS_CMD:    rdMux = 32'h0000_0000;
      OFS_STATUS: rdMux = 32'({refLive_r, seqErr_r, loaded_r, dirFwdOut});
      OFS_FRAME:  rdMux = frame_r;
      OFS_SUB:    rdMux = 32'(sub_r);
      default:    rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      // No write fires while arready stands, so the mux sees araddr
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid && s_axi_arvalid)
        s_axi_arready <= 1'b1;
    end
  end

endmodule

// >>> test/btpd_sva.sv
// Port-level assertions for the position decoder top
`timescale 1ns/1ns
module btpd_sva
  import btpd_pkg::*;
(
  input logic              clk,
  input logic              rst,
  input logic              encA,
  input logic              encB,
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic [31:0]       s_axi_wdata,
  input logic              s_axi_wvalid,
  input logic              s_axi_wready,
  input logic [1:0]        s_axi_bresp,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [31:0]       s_axi_rdata,
  input logic [1:0]        s_axi_rresp,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  input logic              refClkOut,
  input logic              dirFwdOut
);
  // ----------------------------------------------------------------
  // Helpers and checks
  // ----------------------------------------------------------------
  localparam int HOLD_MAX = 2001;
  logic [3:0]  ctrlR;
  logic        refPrevR;
  logic [11:0] idleR;

  // Snoops CTRL; only valid while AW and W are offered together
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrlR <= CTRL_RESET;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
             && s_axi_wready && s_axi_awaddr == OFS_CTRL)
      ctrlR <= s_axi_wdata[3:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refPrevR <= 1'b0;
      idleR <= 12'h000;
    end
    else
    begin
      refPrevR <= refClkOut;
      idleR <= (refClkOut != refPrevR) ? 12'h000 : idleR + 12'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Sync latency is well under eight cycles
  sequence tachSteady;
    (ctrlR[0] && $stable(encB) && $stable(ctrlR)) [*8];
  endsequence
  sequence biQuiet;
    (!ctrlR[0] && $stable({encA, encB, ctrlR})) [*8];
  endsequence

  awPulse_a: assert property
    (s_axi_awready |-> $past(s_axi_awvalid) ##1 !s_axi_awready)
    else $error("awready not a single answered pulse");
  wPulse_a: assert property
    (s_axi_wready |-> $past(s_axi_wvalid) ##1 !s_axi_wready)
    else $error("wready not a single answered pulse");
  bHold_a: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rHold_a: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  writeResp_a: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
     |-> ##2 s_axi_bvalid && s_axi_bresp ==
     ($past(s_axi_awaddr, 2) >= 5'h1C ? RESP_SLVERR : RESP_OKAY))
    else $error("write response wrong or late");
  readResp_a: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp ==
     ($past(s_axi_araddr) >= 5'h1C ? RESP_SLVERR : RESP_OKAY))
    else $error("read response wrong or late");
  refLive_a: assert property (idleR <= HOLD_MAX)
    else $error("reference clock stalled");
  tachDir_a: assert property
    (tachSteady |-> dirFwdOut == !(encB ^ ctrlR[2]))
    else $error("tach direction does not follow level");
  dirQuiet_a: assert property (biQuiet |=> $stable(dirFwdOut))
    else $error("direction moved without a step");
endmodule

bind btpd_top btpd_sva u_sva (
  .clk, .rst, .encA, .encB, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .refClkOut,
  .dirFwdOut
);

// >>> test/btpd_enc_model.sv
// Behavioural transport encoder driving the two encoder waves
`timescale 1ns/1ns
module btpd_enc_model (
  output logic encA,
  output logic encB
);
  // ----------------------------------------------------------------
  // Wave generation
  // ----------------------------------------------------------------
  logic [1:0] phaseR;

  initial
  begin
    phaseR = 2'h0;
    encA = 1'b0;
    encB = 1'b0;
  end

  // Levels held for gapNs, well above two link periods
  task automatic quad(input bit aLead, input int n, input int gapNs);
    for (int i = 0; i < n; i++)
    begin
      phaseR = aLead ? phaseR + 2'h1 : phaseR - 2'h1;
      {encA, encB} = {phaseR[1] ^ phaseR[0], phaseR[1]};
      #(gapNs);
    end
  endtask

  // Both waves jump at once; only the fault scenario asks for it
  task automatic skip(input int gapNs);
    phaseR = phaseR + 2'h2;
    {encA, encB} = {phaseR[1] ^ phaseR[0], phaseR[1]};
    #(gapNs);
  endtask

  // Rate pulses on A with B held as the direction level
  task automatic tach(input bit bLevel, input int n, input int gapNs);
    encA = 1'b0;
    encB = bLevel;
    #(gapNs);
    repeat (n)
    begin
      encA = 1'b1;
      #(gapNs);
      encA = 1'b0;
      #(gapNs);
    end
  endtask
endmodule

// >>> test/btpd_top_tb.sv
// Register-level testbench of the position decoder
`timescale 1ns/1ns
module btpd_top_tb
  import btpd_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic              clk, rst, linkClk, encA, encB;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, refClkOut, dirFwdOut;
  int                n_fail;
  int                cmp_count;

  btpd_top u_btpd_top (
    .clk(clk), .rst(rst), .linkClk(linkClk), .encA(encA), .encB(encB),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .refClkOut(refClkOut), .dirFwdOut(dirFwdOut));

  btpd_enc_model u_enc (.encA(encA), .encB(encB));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Link clock offset so its edges never line up with clk
  initial
  begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang(input int k);
    if (k >= 60)
    begin
      n_fail++;
      $display("Error %0t: bus answer missing", $time);
      test_done();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end
    while (!bvalid && k < 60);
    bready <= 1'b0;
    hang(k);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  // Polls up to n reads for the value a slow path settles to
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY, input int n = 1);
    int k;
    logic [31:0] got;
    logic [1:0]  rsp;
    for (int t = 0; t < n; t++)
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
        k++;
      end
      while (!rvalid && k < 60);
      got = rdata;
      rsp = rresp;
      rready <= 1'b0;
      hang(k);
      if (got === e) break;
    end
    chk(got, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic r;
    int   k;
    n_fail = 0;
    cmp_count = 0;
    rst = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_PPF, 32'h0000_0004);
    rd(OFS_STATUS, 32'h0000_0001);
    wr(5'h1C, 32'h0000_0001, RESP_SLVERR);
    rd(5'h1C, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_PPF, 32'h0000_0000);
    rd(OFS_PPF, 32'h0000_0001);
    wr(OFS_PPF, 32'h0000_0003);
    wr(OFS_START, 32'h0000_000A);
    wr(OFS_CTRL, 32'h0000_0008);
    wr(OFS_CMD, 32'h0000_0001);
    u_enc.quad(1, 7, 200);
    rd(OFS_SUB, 32'h0000_0001, RESP_OKAY, 20);
    rd(OFS_FRAME, 32'h0000_000C, RESP_OKAY, 20);
    rd(OFS_STATUS, 32'h0000_000B);
    u_enc.quad(0, 5, 200);
    rd(OFS_SUB, 32'h0000_0002, RESP_OKAY, 20);
    rd(OFS_FRAME, 32'h0000_000A, RESP_OKAY, 20);
    rd(OFS_STATUS, 32'h0000_000A);
    wr(OFS_CTRL, 32'h0000_000A);
    u_enc.quad(0, 3, 200);
    rd(OFS_FRAME, 32'h0000_000B, RESP_OKAY, 20);
    rd(OFS_STATUS, 32'h0000_000B);
    u_enc.skip(400);
    rd(OFS_STATUS, 32'h0000_000F, RESP_OKAY, 20);
    rd(OFS_SUB, 32'h0000_0002);
    rd(OFS_FRAME, 32'h0000_000B);
    wr(OFS_STATUS, 32'h0000_0004);
    rd(OFS_STATUS, 32'h0000_000B);
    wr(OFS_CTRL, 32'h0000_0002);
    u_enc.quad(1, 4, 200);
    rd(OFS_STATUS, 32'h0000_000A, RESP_OKAY, 20);
    rd(OFS_FRAME, 32'h0000_000B);
    rd(OFS_SUB, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0009);
    wr(OFS_CMD, 32'h0000_0001);
    u_enc.tach(0, 3, 200);
    rd(OFS_FRAME, 32'h0000_000B, RESP_OKAY, 20);
    rd(OFS_SUB, 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_000B);
    u_enc.tach(1, 2, 200);
    rd(OFS_SUB, 32'h0000_0001, RESP_OKAY, 20);
    rd(OFS_FRAME, 32'h0000_000A);
    rd(OFS_STATUS, 32'h0000_000A);
    wr(OFS_CTRL, 32'h0000_000D);
    u_enc.tach(1, 1, 200);
    rd(OFS_SUB, 32'h0000_0002, RESP_OKAY, 20);
    chk({31'h0, dirFwdOut}, 32'h0000_0001);
    // Transport now stopped: reference must keep running
    for (int j = 0; j < 2; j++)
    begin
      r = refClkOut;
      k = 0;
      while (refClkOut === r && k < 2100)
      begin
        @(posedge clk);
        k++;
      end
      chk({31'h0, refClkOut !== r}, 32'h0000_0001);
    end
    test_done();
  end
endmodule
